/* File: rtl/sector_mem_params.svh */
// Constants for the sectored data memory map
`ifndef SECTOR_MEM_PARAMS_SVH
`define SECTOR_MEM_PARAMS_SVH
`define SFR_LAST_OFFSET 8'h7F
`define GPR_FIRST_OFFSET 8'h80
`define ADDR_VALID_BITS 11
`define SECTORS_SMALL 2
`define SECTORS_LARGE 4
`define LED_SECTOR 3'h4
`define LED_BYTES 128
`define SFR_UNUSED_VALUE 8'h00
`define SFR_RESET_VALUE 8'h00
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_BITSET 2'h2
`define OP_BITCLR 2'h3
`endif

/* File: rtl/sector_mem_pkg.sv */
// Types for the sectored data memory map
package sector_mem_pkg;
    typedef enum logic [1:0] {
        OP_RD = 2'h0,
        OP_WR = 2'h1,
        OP_SET = 2'h2,
        OP_CLR = 2'h3
    } mem_op_e;
    typedef enum logic [1:0] {
        SRC_DIRECT = 2'h0,
        SRC_PTR1 = 2'h1,
        SRC_PTR2 = 2'h2
    } addr_src_e;
    typedef struct packed {
        logic valid;
        mem_op_e op;
        addr_src_e src;
        logic [10:0] directAddr;
        logic [2:0] bitSel;
        logic [7:0] wdata;
    } mem_req_s;
    typedef struct packed {
        logic valid;
        logic hit;
        logic [7:0] rdata;
    } mem_rsp_s;
endpackage

/* File: rtl/sectored_data_memory_map.sv */
// Sectored byte-wide data memory with special and general areas
`timescale 1ns/100ps
`include "sector_mem_params.svh"

module sectored_data_memory_map
    import sector_mem_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b0,
    parameter logic [127:0] SFR_USED_MASK = {128{1'b1}},
    parameter logic [127:0] SFR_RO_MASK = 128'h0
)(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Pointer bytes from the core
    input wire logic [7:0] ptr1_sector_byte,
    input wire logic [7:0] ptr1_offset_byte,
    input wire logic [7:0] ptr2_sector_byte,
    input wire logic [7:0] ptr2_offset_byte,
    // Access request and answer
    input wire mem_req_s req,
    output mem_rsp_s rsp
);

    localparam int GPR_SECTORS = LARGE_VARIANT ? `SECTORS_LARGE : `SECTORS_SMALL;
    localparam int SFR_SECTORS = 2;

    // Indexing serves two special sectors and an LED sector above the RAM sectors
    if (SFR_SECTORS > 2 || `LED_SECTOR < `SECTORS_LARGE)
    begin
        $error("Sector layout not served");
    end

    // ****************************************
    // Address resolution
    // ****************************************
    logic [2:0] sector;
    logic [7:0] offset;
    logic isSfr;
    logic secOk;
    logic isLed;

    always_comb
    begin
        case (req.src)
            SRC_PTR1:
            begin
                sector = ptr1_sector_byte[2:0];
                offset = ptr1_offset_byte;
            end
            SRC_PTR2:
            begin
                sector = ptr2_sector_byte[2:0];
                offset = ptr2_offset_byte;
            end
            default:
            begin
                sector = req.directAddr[10:8];
                offset = req.directAddr[7:0];
            end
        endcase
    end

    // Pointer high bits above the sector field must be zero to hit
    logic highOk;
    always_comb
    begin
        if (req.src == SRC_PTR1)
            highOk = (ptr1_sector_byte[7:3] == 5'h00);
        else if (req.src == SRC_PTR2)
            highOk = (ptr2_sector_byte[7:3] == 5'h00);
        else
            highOk = 1'b1;
    end

    assign isSfr = (offset <= `SFR_LAST_OFFSET);
    assign isLed = LARGE_VARIANT && !isSfr && (sector == `LED_SECTOR);
    assign secOk = highOk && (isSfr ? (int'(sector) < SFR_SECTORS)
                                    : (isLed || int'(sector) < GPR_SECTORS));

    // ****************************************
    // Storage, byte wide
    // ****************************************
    logic [7:0] gpr [GPR_SECTORS*128];
    logic [7:0] led [`LED_BYTES];
    logic [7:0] sfr [SFR_SECTORS*128];

    function automatic logic [7:0] modify(input logic [7:0] old, input mem_op_e op,
                                          input logic [2:0] b, input logic [7:0] wd);
        logic [7:0] r;
        r = old;
        case (op)
            OP_WR: r = wd;
            OP_SET: r[b] = 1'b1;
            OP_CLR: r[b] = 1'b0;
            default: r = old;
        endcase
        return r;
    endfunction

    logic [8:0] gIdx;
    logic [7:0] sIdx;
    logic sfrWritable;
    logic [7:0] curByte;
    assign gIdx = {sector[1:0], offset[6:0]};
    assign sIdx = {sector[0], offset[6:0]};
    assign sfrWritable = SFR_USED_MASK[offset[6:0]] && !SFR_RO_MASK[offset[6:0]];

    always_comb
    begin
        if (!secOk)
            curByte = `SFR_UNUSED_VALUE;
        else if (isSfr && !SFR_USED_MASK[offset[6:0]])
            curByte = `SFR_UNUSED_VALUE;
        else if (isSfr)
            curByte = sfr[sIdx];
        else if (isLed)
            curByte = led[offset[6:0]];
        else
            curByte = gpr[gIdx[$clog2(GPR_SECTORS*128)-1:0]];
    end

    logic doWrite;
    assign doWrite = req.valid && secOk && (req.op != OP_RD);

    always_ff @(posedge core_clk)
    begin
        if (doWrite && !isSfr && !isLed)
            gpr[gIdx[$clog2(GPR_SECTORS*128)-1:0]] <=
                modify(curByte, req.op, req.bitSel, req.wdata);
    end

    always_ff @(posedge core_clk)
    begin
        if (doWrite && isLed)
            led[offset[6:0]] <= modify(curByte, req.op, req.bitSel, req.wdata);
    end

    // Special registers reset so read-only ones show a defined value
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < SFR_SECTORS*128; i++)
                sfr[i] <= `SFR_RESET_VALUE;
        end
        else if (doWrite && isSfr && sfrWritable)
            sfr[sIdx] <= modify(curByte, req.op, req.bitSel, req.wdata);
    end

    // ****************************************
    // Answer
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            rsp <= '0;
        else
        begin
            rsp.valid <= req.valid;
            rsp.hit <= req.valid && secOk;
            rsp.rdata <= (req.valid && req.op == OP_RD) ? curByte : 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] pastOff;
    always_ff @(posedge core_clk)
    begin
        pastOff <= offset;
    end

    chk_sfr_range: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.src == SRC_DIRECT && !req.directAddr[7]
        && req.directAddr[10:9] != 2'h0 |=> !rsp.hit)
        else $error("special area hit outside its sectors");
    chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_RD && isSfr && !SFR_USED_MASK[offset[6:0]]
        |=> rsp.rdata == 8'h00) else $error("unused location not zero");
    chk_ptr_sector: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.src == SRC_PTR1 |-> sector == ptr1_sector_byte[2:0]
            && offset == ptr1_offset_byte) else $error("pointer decode wrong");
    chk_direct_split: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.src == SRC_DIRECT |-> {sector, offset} == req.directAddr)
        else $error("direct split wrong");
    chk_gpr_rw: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_WR && secOk && !isSfr && !isLed
        ##1 req.valid && req.op == OP_RD && $stable(offset) && $stable(sector)
        |=> rsp.rdata == $past(req.wdata, 2)) else $error("ram write lost");
    chk_bit_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_SET && secOk && !isSfr
        ##1 req.valid && req.op == OP_RD && $stable(offset) && $stable(sector)
        |=> rsp.rdata == ($past(curByte, 2) | (8'h01 << $past(req.bitSel, 2))))
        else $error("bit set disturbed byte");
    chk_ro_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_WR && secOk && isSfr && SFR_RO_MASK[offset[6:0]]
        |=> sfr[{$past(sector[0]), pastOff[6:0]}] == $past(curByte))
        else $error("read-only register changed");
    chk_led_small: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && !isSfr && highOk && sector == `LED_SECTOR
        |=> rsp.hit == LARGE_VARIANT) else $error("led ram presence wrong");
    chk_hit_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.src == SRC_DIRECT && (req.directAddr[10:9] == 2'h0
        || (LARGE_VARIANT && req.directAddr[7] && req.directAddr[10:8] <= 3'h4))
        |=> rsp.hit) else $error("direct access missed");

    cov_ptr2_read: cover property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.src == SRC_PTR2 && req.op == OP_RD && !isSfr);
    cov_bit_clear: cover property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && req.op == OP_CLR && secOk);
    cov_led_write: cover property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && isLed && req.op == OP_WR);
    cov_sector1: cover property (@(posedge core_clk) disable iff (!rst_b)
        req.valid && sector == 3'h1 && isSfr);

endmodule

/* File: bench/core_side_model.sv */
// Core-side model that issues data memory requests
`timescale 1ns/100ps
module core_side_model
    import sector_mem_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Pointer bytes and request
    output logic [7:0] ptr1_sector_byte,
    output logic [7:0] ptr1_offset_byte,
    output logic [7:0] ptr2_sector_byte,
    output logic [7:0] ptr2_offset_byte,
    output mem_req_s req,
    // Answer
    input wire mem_rsp_s rsp
);
    mem_rsp_s got;
    initial
    begin
        {ptr1_sector_byte, ptr1_offset_byte, ptr2_sector_byte, ptr2_offset_byte} = 32'h0;
        req = '0;
        got = '0;
    end
    task automatic set_ptrs(input logic [7:0] s1, o1, s2, o2);
        @(negedge core_clk);
        {ptr1_sector_byte, ptr1_offset_byte, ptr2_sector_byte, ptr2_offset_byte} = {s1, o1, s2, o2};
    endtask
    // Answer is sampled at the falling edge after the taking edge
    task automatic access(input mem_op_e op, input addr_src_e src, input logic [10:0] a,
        input logic [2:0] b, input logic [7:0] wd);
        @(negedge core_clk);
        req = '{valid: 1'b1, op: op, src: src, directAddr: a, bitSel: b, wdata: wd};
        @(negedge core_clk);
        // Released address and write data must not keep their last value
        req = '{valid: 1'b0, op: op, src: src, directAddr: ~a, bitSel: b, wdata: ~wd};
        got = rsp;
    endtask
    // Two requests on consecutive edges; the answer to the second is kept
    task automatic access_pair(input mem_op_e op1, input mem_op_e op2, input logic [10:0] a,
        input logic [2:0] b, input logic [7:0] wd);
        @(negedge core_clk);
        req = '{valid: 1'b1, op: op1, src: SRC_DIRECT, directAddr: a, bitSel: b, wdata: wd};
        @(negedge core_clk);
        req = '{valid: 1'b1, op: op2, src: SRC_DIRECT, directAddr: a, bitSel: b, wdata: ~wd};
        @(negedge core_clk);
        req = '{valid: 1'b0, op: op2, src: SRC_DIRECT, directAddr: ~a, bitSel: b, wdata: wd};
        got = rsp;
    endtask
endmodule

/* File: bench/sectored_data_memory_map_tb.sv */
// Self-checking bench for the sectored data memory map
`timescale 1ns/100ps
module sectored_data_memory_map_tb;
    import sector_mem_pkg::*;
    logic core_clk;
    logic rst_b;
    logic [7:0] p1s, p1o, p2s, p2o;
    mem_req_s req;
    mem_rsp_s rsp;
    int errTotal = 0;
    int comparisons = 0;
    int cycles = 0;
    core_side_model core_side_model_i (.core_clk(core_clk), .ptr1_sector_byte(p1s),
        .ptr1_offset_byte(p1o), .ptr2_sector_byte(p2s), .ptr2_offset_byte(p2o),
        .req(req), .rsp(rsp));
    sectored_data_memory_map #(.LARGE_VARIANT(1'b1), .SFR_USED_MASK(~128'h800),
        .SFR_RO_MASK(128'h8000)) sectored_data_memory_map_i (.core_clk(core_clk),
        .rst_b(rst_b), .ptr1_sector_byte(p1s), .ptr1_offset_byte(p1o),
        .ptr2_sector_byte(p2s), .ptr2_offset_byte(p2o), .req(req), .rsp(rsp));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, ample for the short sequence below
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errTotal++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic hit, input logic [7:0] exp);
        mem_rsp_s g;
        g = core_side_model_i.got;
        comparisons++;
        if ({g.valid, g.hit, g.rdata} !== {1'b1, hit, exp})
        begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", what, {1'b1, hit, exp},
                {g.valid, g.hit, g.rdata});
        end
    endtask
    task automatic run_op(input mem_op_e op, input logic [10:0] a, input logic [2:0] b,
        input logic [7:0] wd);
        core_side_model_i.access(op, SRC_DIRECT, a, b, wd);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic gpr_sectors();
        for (int s = 0; s < 6; s++)
        begin
            run_op(OP_WR, {s[2:0], 8'h80} + 11'(s), 3'h0, 8'(8'h11 * s + 8'h03));
            check("gpr write", s < 5, 8'h00);
            run_op(OP_RD, {s[2:0], 8'h80} + 11'(s), 3'h0, 8'h00);
            check("gpr read", s < 5, s < 5 ? 8'(8'h11 * s + 8'h03) : 8'h00);
        end
        run_op(OP_WR, 11'h0FF, 3'h0, 8'hE7);
        run_op(OP_RD, 11'h0FF, 3'h0, 8'h00);
        check("gpr top offset hit", 1'b1, 8'hE7);
    endtask
    task automatic back_to_back();
        core_side_model_i.access_pair(OP_WR, OP_RD, 11'h3A0, 3'h0, 8'h96);
        check("read after write", 1'b1, 8'h96);
        core_side_model_i.access_pair(OP_SET, OP_RD, 11'h3A0, 3'h3, 8'h00);
        check("read after bit set", 1'b1, 8'h9E);
    endtask
    task automatic ptr_access();
        core_side_model_i.set_ptrs(8'h02, 8'h90, 8'h03, 8'hFF);
        core_side_model_i.access(OP_WR, SRC_PTR1, 11'h000, 3'h0, 8'hA5);
        core_side_model_i.access(OP_WR, SRC_PTR2, 11'h000, 3'h0, 8'h3C);
        run_op(OP_RD, 11'h290, 3'h0, 8'h00);
        check("ptr1 sector", 1'b1, 8'hA5);
        run_op(OP_RD, 11'h3FF, 3'h0, 8'h00);
        check("ptr2 sector", 1'b1, 8'h3C);
        core_side_model_i.set_ptrs(8'h0A, 8'h90, 8'h03, 8'hFF);
        core_side_model_i.access(OP_RD, SRC_PTR1, 11'h000, 3'h0, 8'h00);
        check("ptr high bits", 1'b0, 8'h00);
    endtask
    task automatic bit_ops();
        run_op(OP_WR, 11'h1C0, 3'h0, 8'h0F);
        run_op(OP_SET, 11'h1C0, 3'h7, 8'h00);
        run_op(OP_RD, 11'h1C0, 3'h0, 8'h00);
        check("bit set", 1'b1, 8'h8F);
        run_op(OP_CLR, 11'h1C0, 3'h0, 8'hFF);
        run_op(OP_RD, 11'h1C0, 3'h0, 8'h00);
        check("bit clear", 1'b1, 8'h8E);
    endtask
    task automatic sfr_area();
        run_op(OP_WR, 11'h010, 3'h0, 8'h5A);
        run_op(OP_RD, 11'h010, 3'h0, 8'h00);
        check("sfr read write", 1'b1, 8'h5A);
        run_op(OP_WR, 11'h17F, 3'h0, 8'hC3);
        run_op(OP_RD, 11'h17F, 3'h0, 8'h00);
        check("sfr top offset", 1'b1, 8'hC3);
        run_op(OP_WR, 11'h00F, 3'h0, 8'hFF);
        run_op(OP_SET, 11'h00F, 3'h2, 8'h00);
        run_op(OP_RD, 11'h00F, 3'h0, 8'h00);
        check("sfr read only", 1'b1, 8'h00);
        run_op(OP_WR, 11'h00B, 3'h0, 8'hFF);
        run_op(OP_RD, 11'h00B, 3'h0, 8'h00);
        check("sfr unused", 1'b1, 8'h00);
        run_op(OP_RD, 11'h210, 3'h0, 8'h00);
        check("sfr absent sector", 1'b0, 8'h00);
    endtask
    initial
    begin
        rst_b = 1'b0;
        repeat (12) @(negedge core_clk);
        rst_b = 1'b1;
        gpr_sectors();
        ptr_access();
        bit_ops();
        back_to_back();
        sfr_area();
        complete_run();
    end
endmodule
